// ### bench/scan_properties.sv
// concurrent checks on the register port of the table scan engine
// assumes a bind onto table_scan_engine and the offsets of scan_params.svh
`timescale 1ns/1ps
`default_nettype none
`include "scan_params.svh"

module scan_properties (
    input wire logic CLK_SYS_I, // core clock
    input wire logic RST_B_I, // sync reset, active low
    input wire logic [7:0] REG_ADDR_I, // register address
    input wire logic [31:0] REG_WDATA_I, // write data
    input wire logic REG_WR_I, // write strobe
    input wire logic REG_RD_I, // read strobe
    input wire logic [31:0] REG_RDATA_O, // read data
    input wire logic SCAN_BUSY_O // go bit
);
    import scan_pkg::*;
    logic go_w;
    logic [2:0] cmd_w;

    // an accepted launch of any command
    assign go_w = REG_WR_I && REG_ADDR_I == `OFS_ACCESS_CTRL
        && REG_WDATA_I[0] && !SCAN_BUSY_O;
    assign cmd_w = REG_WDATA_I[3:1];

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);

    property p_rdata_idle;
        !REG_RD_I |=> REG_RDATA_O == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read answer");
    property p_wdir;
        go_w && cmd_w == CMD_WRITE |=> SCAN_BUSY_O ##1 !SCAN_BUSY_O;
    endproperty
    a_wdir: assert property (p_wdir)
        else $error("write direct busy length wrong");
    property p_rdir;
        go_w && cmd_w == CMD_READ |=> SCAN_BUSY_O [*3] ##1 !SCAN_BUSY_O;
    endproperty
    a_rdir: assert property (p_rdir)
        else $error("read direct busy length wrong");
    property p_scan;
        go_w && cmd_w == CMD_SCAN |=> SCAN_BUSY_O [*2] ##[1:200] !SCAN_BUSY_O;
    endproperty
    a_scan: assert property (p_scan)
        else $error("scan did not run or did not end");
    property p_cause;
        $rose(SCAN_BUSY_O) |-> $past(go_w);
    endproperty
    a_cause: assert property (p_cause)
        else $error("busy rose without a go write");
    property p_go_read;
        REG_RD_I && REG_ADDR_I == `OFS_ACCESS_CTRL
            |=> REG_RDATA_O[0] == $past(SCAN_BUSY_O);
    endproperty
    a_go_read: assert property (p_go_read)
        else $error("go bit read differs from busy");
    property p_unmapped;
        REG_RD_I && REG_ADDR_I > `OFS_EVENT_STICKY |=> REG_RDATA_O == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_total_w;
        REG_RD_I && REG_ADDR_I == `OFS_MATCH_TOTAL
            |=> REG_RDATA_O[31:7] == 25'h0;
    endproperty
    a_total_w: assert property (p_total_w)
        else $error("match total wider than its field");
    property p_sticky_w;
        REG_RD_I && REG_ADDR_I == `OFS_EVENT_STICKY
            |=> REG_RDATA_O[31:2] == 30'h0;
    endproperty
    a_sticky_w: assert property (p_sticky_w)
        else $error("sticky word has stray bits");
    property p_sticky_clr;
        (REG_WR_I && REG_ADDR_I == `OFS_EVENT_STICKY && !SCAN_BUSY_O
            && REG_WDATA_I[1:0] == 2'h3) ##1 !REG_WR_I
            ##1 (REG_RD_I && REG_ADDR_I == `OFS_EVENT_STICKY)
            |=> REG_RDATA_O == 32'h0;
    endproperty
    a_sticky_clr: assert property (p_sticky_clr)
        else $error("sticky bits survived a clear");

    // main scenarios reached
    c_scan: cover property (go_w && cmd_w == CMD_SCAN);
    c_rdir: cover property (go_w && cmd_w == CMD_READ);
    c_unmapped: cover property (REG_RD_I && REG_ADDR_I > `OFS_EVENT_STICKY);
endmodule : scan_properties
`default_nettype wire

// ### bench/tb_top.sv
// register-level bench of the table scan engine
// assumes the register map of scan_params.svh and a 100 MHz core clock
`timescale 1ns/1ps
`default_nettype none
`include "scan_params.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error %0t: got %h want %h", $time, g, e); end end

module tb_top;
    import scan_pkg::*;
    logic clk = 1'b0;
    logic rst_b;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_s;
    logic rd_s;
    logic [31:0] rdata;
    logic busy;
    logic [31:0] got;
    int err_total = 0;
    int n_checks = 0;
    logic [7:0] ra [8] = '{8'h00, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20,
        8'h24, 8'h30};
    logic [31:0] rv [8] = '{32'h0A, 32'h1E0, 32'h0FFF_0000, 32'h3, 32'h0,
        32'h0, 32'h0, 32'h0};
    localparam logic [31:0] NO = 32'hFFFF_FFFF;

    always #5 clk = ~clk;

    table_scan_engine dut (
        .CLK_SYS_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
        .REG_RDATA_O(rdata), .SCAN_BUSY_O(busy)
    );

    // one-cycle write and read strobes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 got = rdata;
    endtask : rd
    task automatic crd(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(got, e)
    endtask : crd
    // launch a command and wait, bounded, for the go bit to fall
    task automatic run(input logic [5:0] idx, input logic [2:0] cmd);
        int n;
        wr(`OFS_ACCESS_CTRL, {22'h0, idx, cmd, 1'b1});
        #1 `CHK(busy, 1'b1)
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(busy, 1'b0)
    endtask : run
    task automatic put(input logic [5:0] i, input logic [31:0] f,
        input logic [31:0] w);
        wr(`OFS_ENTRY_WORD_ZERO, f);
        wr(`OFS_ENTRY_WORD_TWO, w);
        run(i, CMD_WRITE);
    endtask : put
    task automatic get(input logic [5:0] i);
        run(i, CMD_READ);
        rd(`OFS_ENTRY_WORD_TWO);
    endtask : get
    task automatic scan(input logic [31:0] cfg, input logic [5:0] i,
        input logic [31:0] tot, input logic [31:0] pos);
        wr(`OFS_SCAN_CFG, cfg);
        run(i, CMD_SCAN);
        if (tot !== NO) crd(`OFS_MATCH_TOTAL, tot);
        crd(`OFS_LATEST_POS, pos);
    endtask : scan
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // watchdog against a hung command
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude();
    end

    // main sequence
    initial begin
        rst_b = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) crd(ra[i], rv[i]);
        $display("test reset done");
        put(6'd5, 32'h123, 32'h0023_0012);
        put(6'd9, 32'h123, 32'h0021_8034);
        put(6'd20, 32'h456, 32'h0020_0012);
        put(6'd40, 32'h123, 32'h0026_0012);
        get(6'd9);
        `CHK(got, 32'h0021_8034)
        wr(`OFS_ENTRY_WORD_ZERO, 32'h123);
        scan(32'h9E1, 6'd0, NO, 32'h105);
        scan(32'h9E1, 6'd8, NO, 32'h109);
        scan(32'h9E9, 6'd8, NO, 32'h128);
        crd(`OFS_EVENT_STICKY, 32'h2);
        $display("test find next done");
        wr(`OFS_ENTRY_WORD_TWO, 32'h12);
        wr(`OFS_SCAN_CFG_ONE, 32'h0FFF_0000);
        scan(32'h1E2, 6'd0, 32'd3, 32'h128);
        wr(`OFS_SCAN_CFG_ONE, 32'h0);
        scan(32'h1E2, 6'd0, 32'd4, 32'h128);
        scan(32'h40, 6'd0, 32'd1, 32'h128);
        scan(32'h1F0, 6'd0, 32'd1, 32'h105);
        wr(`OFS_ENTRY_WORD_TWO, 32'h0001_0000);
        scan(32'h3E0, 6'd0, 32'd1, 32'h109);
        $display("test filters done");
        scan(32'h401E0, 6'd0, 32'd4, 32'h128);
        crd(`OFS_EVENT_STICKY, 32'h3);
        get(6'd5);
        `CHK(got[21], 1'b0)
        get(6'd9);
        `CHK(got, 32'h0021_8034)
        get(6'd20);
        `CHK(got, 32'h0021_0012)
        get(6'd40);
        `CHK(got, 32'h0027_0012)
        $display("test aging done");
        wr(`OFS_ENTRY_WORD_TWO, 32'h12);
        wr(`OFS_SCAN_CFG_ONE, 32'h0FFF_0ABC);
        scan(32'h101E2, 6'd0, 32'd2, 32'h128);
        get(6'd20);
        `CHK(got, 32'h0021_0ABC)
        crd(`OFS_ENTRY_WORD_ZERO, 32'h456);
        wr(`OFS_EVENT_STICKY, 32'h3);
        crd(`OFS_EVENT_STICKY, 32'h0);
        wr(`OFS_ENTRY_WORD_ZERO, 32'h456);
        scan(32'h201E1, 6'd0, 32'd1, 32'h114);
        crd(`OFS_EVENT_STICKY, 32'h3);
        get(6'd20);
        `CHK(got[21], 1'b0)
        scan(32'hA1E0, 6'd0, 32'd2, 32'h128);
        get(6'd40);
        `CHK(got, 32'h0034_0ABC)
        wr(`OFS_ENTRY_WORD_TWO, 32'h0002_0000);
        scan(32'h5E0, 6'd0, 32'd0, 32'h028);
        scan(32'h51E0, 6'd0, 32'd2, 32'h128);
        get(6'd40);
        `CHK(got, 32'h0026_0ABC)
        wr(`OFS_PORT_FILTER, 32'h0010_0000);
        crd(`OFS_PORT_FILTER, 32'h0010_0000);
        scan(32'h1E4, 6'd0, 32'd1, 32'h109);
        $display("test actions done");
        wr(`OFS_SCAN_CFG, 32'h1E0);
        wr(`OFS_ACCESS_CTRL, 32'h0B);
        wr(`OFS_ACCESS_CTRL, 32'h3C1);
        rd(`OFS_ACCESS_CTRL);
        `CHK(got[0], 1'b1)
        repeat (300) @(posedge clk);
        crd(`OFS_ACCESS_CTRL, 32'h0A);
        crd(8'h30, 32'h0);
        run(6'd0, 3'h0);
        crd(`OFS_ACCESS_CTRL, 32'h00);
        $display("test busy done");
        conclude();
    end
endmodule : tb_top

bind table_scan_engine scan_properties u_props (
    .CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .SCAN_BUSY_O(SCAN_BUSY_O)
);
`default_nettype wire

// ### verilog/entry_filter.sv
// combinational filter deciding whether one entry matches the scan
// assumes all inputs are stable register outputs of the same clock
`timescale 1ns/1ps
`default_nettype none
`include "scan_params.svh"

module entry_filter (
    input wire scan_pkg::entry_t ent_i, // entry under test
    input wire scan_pkg::entry_t ref_i, // reference from entry words
    input wire logic [18:0] cfg_i, // scan configuration
    input wire logic [11:0] addr_mask_i, // significant address bits
    input wire logic [15:0] local_ports_i, // local aging ports
    input wire logic [15:0] other_ports_i, // other-unit aging ports
    input wire logic [1:0] age_max_i, // configured maximum age
    output logic match_o, // entry meets every enabled filter
    output logic stale_o // age counter at maximum
);
    import scan_pkg::*;

    logic port_ok;
    logic [3:0] ivl_mask;

    always_comb begin
        ivl_mask = cfg_i[`POS_IVL_MASK +: 4];
        stale_o = (ent_i.age == age_max_i);
        // port filter: kind 0 holds unit in [11:4], port in [3:0]
        port_ok = 1'b0;
        if (ent_i.kind == 3'h0) begin
            if (ent_i.value[11:4] == 8'h00) begin
                port_ok = local_ports_i[ent_i.value[3:0]];
            end else begin
                port_ok = other_ports_i[ent_i.value[3:0]];
            end
        end
        match_o = ent_i.valid;
        if (cfg_i[`POS_FID_EN] && ent_i.fid != ref_i.fid) begin
            match_o = 1'b0;
        end
        if (cfg_i[`POS_ADDR_EN] && (ent_i.kind != ref_i.kind ||
            ((ent_i.value ^ ref_i.value) & addr_mask_i) != 12'h000)) begin
            match_o = 1'b0;
        end
        if (cfg_i[`POS_PORT_EN] && !port_ok) begin
            match_o = 1'b0;
        end
        if (cfg_i[`POS_SKIP_PIN] && ent_i.pinned) begin
            match_o = 1'b0;
        end
        if (cfg_i[`POS_STALE] && !stale_o) begin
            match_o = 1'b0;
        end
        if (!ivl_mask[ent_i.interval]) begin
            match_o = 1'b0;
        end
        if (cfg_i[`POS_AGE_FILT] && ent_i.age != ref_i.age) begin
            match_o = 1'b0;
        end
        if (cfg_i[`POS_LA_FILT] && ent_i.learn_all != ref_i.learn_all) begin
            match_o = 1'b0;
        end
    end

endmodule : entry_filter

`default_nettype wire

// ### verilog/entry_store.sv
// table memory: 64 entries, one write port, registered read
// assumes reads and writes come from the same clock domain
`timescale 1ns/1ps
`default_nettype none

module entry_store (
    input wire logic CLK_SYS_I, // core clock
    input wire logic RST_B_I, // sync reset, active low
    input wire logic we_i, // write strobe
    input wire logic [5:0] waddr_i, // write index
    input wire scan_pkg::entry_t wdata_i, // write entry
    input wire logic [5:0] raddr_i, // read index
    output scan_pkg::entry_t rdata_o // read entry, one cycle later
);
    import scan_pkg::*;

    typedef struct packed {
        logic [63:0][34:0] mem;
        entry_t rdata;
    } store_t;

    store_t s_q;
    store_t s_d;

    // write and read path
    always_comb begin
        s_d = s_q;
        s_d.rdata = entry_t'(s_q.mem[raddr_i]);
        if (we_i) begin
            s_d.mem[waddr_i] = wdata_i;
        end
    end

    // storage, table empty after reset
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;

endmodule : entry_store

`default_nettype wire

// ### verilog/scan_params.svh
// register map, field positions and reset values of the table scan engine
// assumes a byte-addressed word port with 32-bit data
`ifndef SCAN_PARAMS_SVH
`define SCAN_PARAMS_SVH

`define OFS_ACCESS_CTRL 8'h00
`define OFS_ENTRY_WORD_ZERO 8'h04
`define OFS_ENTRY_WORD_TWO 8'h08
`define OFS_SCAN_CFG 8'h0C
`define OFS_SCAN_CFG_ONE 8'h10
`define OFS_PORT_FILTER 8'h14
`define OFS_AGE_MAX 8'h18
`define OFS_LATEST_POS 8'h1C
`define OFS_MATCH_TOTAL 8'h20
`define OFS_EVENT_STICKY 8'h24

// access control fields
`define POS_GO 0
`define POS_CMD 1
`define POS_COL 4
`define POS_ROW 6

// scan configuration fields
`define POS_FID_EN 0
`define POS_ADDR_EN 1
`define POS_PORT_EN 2
`define POS_SKIP_PIN 3
`define POS_STALE 4
`define POS_IVL_MASK 5
`define POS_AGE_FILT 9
`define POS_LA_FILT 10
`define POS_STOP 11
`define POS_AGE_SEL 12
`define POS_LA_SEL 14
`define POS_RELOC 16
`define POS_DELETE 17
`define POS_SWAGE 18

// second scan configuration word
`define POS_NEW_ADDR 0
`define POS_ADDR_MASK 16

// status fields
`define POS_POS_VALID 8
`define POS_STK_REMOVED 0
`define POS_STK_ROWMATCH 1

// reset values
`define RST_IVL_MASK 4'hF
`define RST_ADDR_MASK 12'hFFF
`define RST_AGE_MAX 2'h3

`endif

// ### verilog/scan_pkg.sv
// types shared by the table scan engine files
// assumes scan_params.svh supplies the numeric register map
package scan_pkg;

    // one table entry, 35 bits
    typedef struct packed {
        logic valid;
        logic [12:0] fid;
        logic [2:0] kind;
        logic [11:0] value;
        logic pinned;
        logic [1:0] age;
        logic [1:0] interval;
        logic learn_all;
    } entry_t;

    typedef enum logic [2:0] {
        CMD_WRITE = 3'h1,
        CMD_READ = 3'h2,
        CMD_SCAN = 3'h5
    } cmd_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_FETCH = 4'h2,
        S_CHECK = 4'h4,
        S_SPARE = 4'h8
    } fsm_t;

endpackage : scan_pkg

// ### verilog/table_scan_engine.sv
// table scan engine: register port, command sequencer, scan actions
// assumes a single core clock and a port master that never waits
// assumes software leaves the configuration alone while busy
//
// Functional notes
// - walk entries; halt at a match or modify every match.
// - find-next starts at the row and column of access control.
// - command 5 with the go bit set starts a scan.
// - go bit clears when the scan ends; busy while it reads one.
// - identifier filter matches entries with the word-zero identifier.
// - address filter matches kind and value; cleared mask bits are wildcards.
// - port filter keeps entries on selected local or other-unit ports.
// - skip-pinned enable excludes pinned entries.
// - stale-only enable keeps entries whose age equals the maximum.
// - interval mask selects which interval tags may match.
// - optional compare of age counter and learn-all flag to word two.
// - stop-on-match halts at first match, else scans on to the last entry.
// - age rewrite select updates the age of every match.
// - learn-all rewrite select updates the flag of every match.
// - relocate writes new address into masked bits of matches.
// - delete removes matches and sets the removed sticky bit.
// - software aging removes entries at maximum, increments others.
// - latest position holds the index of the last match.
// - match total counts matches of the current scan.
// - a match sets the row-match sticky bit.
// - pinned entries are left alone by software aging.
`timescale 1ns/1ps
`default_nettype none
`include "scan_params.svh"

module table_scan_engine (
    input wire logic CLK_SYS_I, // core clock, 100 MHz
    input wire logic RST_B_I, // sync reset, active low
    input wire logic [7:0] REG_ADDR_I, // register byte address
    input wire logic [31:0] REG_WDATA_I, // write data
    input wire logic REG_WR_I, // write strobe
    input wire logic REG_RD_I, // read strobe
    output logic [31:0] REG_RDATA_O, // read data, cycle after strobe
    output logic SCAN_BUSY_O // go bit, command running
);
    import scan_pkg::*;

    typedef struct packed {
        // sequencer and access control
        fsm_t st;
        logic one_shot_go_bit;
        cmd_t cmd;
        logic [3:0] row;
        logic [1:0] col;
        // entry words and scan configuration
        logic [12:0] word_zero;
        logic [21:0] word_two;
        logic [18:0] cfg;
        logic [11:0] new_addr;
        logic [11:0] addr_mask;
        // port filter and aging limit
        logic [15:0] local_ports;
        logic [15:0] other_ports;
        logic [1:0] age_max;
        // walk position and scan status
        logic [5:0] idx;
        logic [5:0] last_pos;
        logic pos_valid;
        logic [6:0] match_total;
        logic stk_removed;
        logic stk_rowmatch;
        // registered read answer
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    // memory data, filter verdict and write port
    entry_t rd_entry;
    entry_t ref_entry;
    entry_t upd_entry;
    logic hit;
    logic stale;
    logic we;
    logic removed;
    logic [5:0] waddr;
    entry_t wdata;

    // starting index from row and column fields
    function automatic logic [5:0] start_index(input logic [3:0] r,
                                               input logic [1:0] c);
        start_index = {r, c};
    endfunction : start_index

    // reference entry assembled from the two entry words
    function automatic entry_t words_to_entry(input logic [12:0] w0,
                                              input logic [21:0] w2);
        entry_t e;
        e.valid = w2[21];
        e.fid = w0;
        e.kind = w2[14:12];
        e.value = w2[11:0];
        e.pinned = w2[15];
        e.age = w2[17:16];
        e.interval = w2[19:18];
        e.learn_all = w2[20];
        words_to_entry = e;
    endfunction : words_to_entry

    // reference for filters and for write direct
    assign ref_entry = words_to_entry(s_q.word_zero, s_q.word_two);

    // table memory, data one cycle after the index
    entry_store u_store (
        .CLK_SYS_I(CLK_SYS_I),
        .RST_B_I(RST_B_I),
        .we_i(we),
        .waddr_i(waddr),
        .wdata_i(wdata),
        .raddr_i(s_q.idx),
        .rdata_o(rd_entry)
    );

    // filter on the entry just read
    entry_filter u_filter (
        .ent_i(rd_entry),
        .ref_i(ref_entry),
        .cfg_i(s_q.cfg),
        .addr_mask_i(s_q.addr_mask),
        .local_ports_i(s_q.local_ports),
        .other_ports_i(s_q.other_ports),
        .age_max_i(s_q.age_max),
        .match_o(hit),
        .stale_o(stale)
    );

    // modifications applied to a matching entry
    always_comb begin
        // defaults: entry unchanged, nothing removed
        upd_entry = rd_entry;
        removed = 1'b0;
        // age rewrite: 1 loads word two, 2 clears
        unique case (s_q.cfg[`POS_AGE_SEL +: 2])
            2'h1: upd_entry.age = ref_entry.age;
            2'h2: upd_entry.age = 2'h0;
            default: upd_entry.age = upd_entry.age;
        endcase
        // learn-all rewrite: 1 clears, 2 sets
        unique case (s_q.cfg[`POS_LA_SEL +: 2])
            2'h1: upd_entry.learn_all = 1'b0;
            2'h2: upd_entry.learn_all = 1'b1;
            default: upd_entry.learn_all = upd_entry.learn_all;
        endcase
        if (s_q.cfg[`POS_RELOC]) begin
            upd_entry.value = (rd_entry.value & ~s_q.addr_mask) |
                              (s_q.new_addr & s_q.addr_mask);
        end
        if (s_q.cfg[`POS_SWAGE] && !rd_entry.pinned) begin
            if (stale) begin
                upd_entry.valid = 1'b0;
                removed = 1'b1;
            end else begin
                upd_entry.age = 2'(rd_entry.age + 2'h1);
            end
        end
        if (s_q.cfg[`POS_DELETE]) begin
            upd_entry.valid = 1'b0;
            removed = 1'b1;
        end
    end

    // register port, command sequencer and scan walk
    always_comb begin
        s_d = s_q;
        we = 1'b0;
        waddr = s_q.idx;
        wdata = upd_entry;
        s_d.rdata = 32'h0000_0000;

        // register writes; access control locked while busy
        if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                `OFS_ACCESS_CTRL: begin
                    if (!s_q.one_shot_go_bit) begin
                        s_d.one_shot_go_bit = REG_WDATA_I[`POS_GO];
                        s_d.cmd = cmd_t'(REG_WDATA_I[`POS_CMD +: 3]);
                        s_d.col = REG_WDATA_I[`POS_COL +: 2];
                        s_d.row = REG_WDATA_I[`POS_ROW +: 4];
                    end
                end
                // configuration words, writable at any time
                `OFS_ENTRY_WORD_ZERO: s_d.word_zero = REG_WDATA_I[12:0];
                `OFS_ENTRY_WORD_TWO: s_d.word_two = REG_WDATA_I[21:0];
                `OFS_SCAN_CFG: s_d.cfg = REG_WDATA_I[18:0];
                `OFS_SCAN_CFG_ONE: begin
                    s_d.new_addr = REG_WDATA_I[`POS_NEW_ADDR +: 12];
                    s_d.addr_mask = REG_WDATA_I[`POS_ADDR_MASK +: 12];
                end
                `OFS_PORT_FILTER: begin
                    s_d.local_ports = REG_WDATA_I[15:0];
                    s_d.other_ports = REG_WDATA_I[31:16];
                end
                `OFS_AGE_MAX: s_d.age_max = REG_WDATA_I[1:0];
                // write one to clear; a set below wins
                `OFS_EVENT_STICKY: begin
                    if (REG_WDATA_I[`POS_STK_REMOVED]) begin
                        s_d.stk_removed = 1'b0;
                    end
                    if (REG_WDATA_I[`POS_STK_ROWMATCH]) begin
                        s_d.stk_rowmatch = 1'b0;
                    end
                end
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // register reads, data registered for the next cycle
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                // go bit reads back as busy
                `OFS_ACCESS_CTRL: s_d.rdata = {22'h0, s_q.row, s_q.col,
                                               s_q.cmd, s_q.one_shot_go_bit};
                `OFS_ENTRY_WORD_ZERO: s_d.rdata = {19'h0, s_q.word_zero};
                `OFS_ENTRY_WORD_TWO: s_d.rdata = {10'h0, s_q.word_two};
                `OFS_SCAN_CFG: s_d.rdata = {13'h0, s_q.cfg};
                `OFS_SCAN_CFG_ONE: s_d.rdata = {4'h0, s_q.addr_mask,
                                                4'h0, s_q.new_addr};
                `OFS_PORT_FILTER: s_d.rdata = {s_q.other_ports,
                                               s_q.local_ports};
                `OFS_AGE_MAX: s_d.rdata = {30'h0, s_q.age_max};
                `OFS_LATEST_POS: s_d.rdata = {23'h0, s_q.pos_valid,
                                              2'h0, s_q.last_pos};
                `OFS_MATCH_TOTAL: s_d.rdata = {25'h0, s_q.match_total};
                `OFS_EVENT_STICKY: s_d.rdata = {30'h0, s_q.stk_rowmatch,
                                                s_q.stk_removed};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // command sequencer and table walk
        unique case (s_q.st)
            S_IDLE: begin
                // command decode on the go bit
                if (s_q.one_shot_go_bit) begin
                    s_d.idx = start_index(s_q.row, s_q.col);
                    unique case (s_q.cmd)
                        CMD_SCAN: begin
                            s_d.match_total = 7'h00;
                            s_d.pos_valid = 1'b0;
                            s_d.st = S_FETCH;
                        end
                        CMD_READ: s_d.st = S_FETCH;
                        CMD_WRITE: begin
                            we = 1'b1;
                            waddr = start_index(s_q.row, s_q.col);
                            wdata = ref_entry;
                            s_d.one_shot_go_bit = 1'b0;
                        end
                        // unknown codes load idx and drop the go bit
                        default: s_d.one_shot_go_bit = 1'b0;
                    endcase
                end
            end
            // memory is addressed by idx; data arrive next cycle
            S_FETCH: s_d.st = S_CHECK;
            S_CHECK: begin
                // read direct copies the entry into the words
                if (s_q.cmd == CMD_READ) begin
                    s_d.word_zero = rd_entry.fid;
                    s_d.word_two = {rd_entry.valid, rd_entry.learn_all,
                                    rd_entry.interval, rd_entry.age,
                                    rd_entry.pinned, rd_entry.kind,
                                    rd_entry.value};
                    s_d.one_shot_go_bit = 1'b0;
                    s_d.st = S_IDLE;
                end else begin
                    s_d.st = S_FETCH;
                    if (hit) begin
                        s_d.match_total = 7'(s_q.match_total + 7'h01);
                        s_d.last_pos = s_q.idx;
                        s_d.pos_valid = 1'b1;
                        s_d.stk_rowmatch = 1'b1;
                        if (s_q.cfg[`POS_STOP]) begin
                            s_d.st = S_IDLE;
                        end else begin
                            // scan-all writes the entry back
                            we = 1'b1;
                            if (removed) begin
                                s_d.stk_removed = 1'b1;
                            end
                        end
                    end
                    // last entry of the table ends the walk
                    if (s_q.idx == 6'h3F) begin
                        s_d.st = S_IDLE;
                    end else begin
                        s_d.idx = 6'(s_q.idx + 6'h01);
                    end
                    // go bit clears at the end of the scan
                    if (s_d.st == S_IDLE) begin
                        s_d.one_shot_go_bit = 1'b0;
                        // idx stays on the last checked entry
                        s_d.idx = s_q.idx;
                    end
                end
            end
            default: begin
                s_d.st = S_IDLE;
                s_d.one_shot_go_bit = 1'b0;
            end
        endcase
    end

    // state register with reset values
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            s_q <= '0;
            s_q.st <= S_IDLE;
            s_q.cmd <= CMD_SCAN;
            // masks open and age limit at maximum
            s_q.cfg[`POS_IVL_MASK +: 4] <= `RST_IVL_MASK;
            s_q.addr_mask <= `RST_ADDR_MASK;
            s_q.age_max <= `RST_AGE_MAX;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from registers
    assign REG_RDATA_O = s_q.rdata;
    assign SCAN_BUSY_O = s_q.one_shot_go_bit;

endmodule : table_scan_engine

`default_nettype wire
